// [common/pll_chain_pkg.sv]
// constants and types of the pll serial reconfiguration chain
package pll_chain_pkg;
  // ----------------------------------------------------------------
  // chain layout
  // ----------------------------------------------------------------
  localparam int CHAIN_LEN = 180;
  localparam int DIV_COUNT = 9;
  localparam int DIV_BITS = 18;
  localparam int CNT_W = 8;
  localparam int HALF_W = 9;
  // block order in the chain: post-scale 0..6, feedback, prescale
  localparam int BLK_FEEDBACK = 7;
  localparam int BLK_PRESCALE = 8;
  // bandwidth fields sit above the divider blocks, loop filter last
  localparam int CP_OFS = 162;
  localparam int CP_W = 3;
  localparam int K_OFS = 165;
  localparam int UNUSED_OFS = 166;
  localparam int UNUSED_W = 7;
  localparam int LFC_OFS = 173;
  localparam int LFC_W = 2;
  localparam int LFR_OFS = 175;
  localparam int LFR_W = 5;
  // low count first, then high count, bypass, odd duty
  typedef struct packed {
    logic odd;
    logic bypass;
    logic [CNT_W-1:0] hi;
    logic [CNT_W-1:0] lo;
  } div_setting_type;
  localparam logic [HALF_W-1:0] HALF_ONE = 9'h001;
  localparam logic [HALF_W-1:0] HALF_ZERO = 9'h000;
  // ----------------------------------------------------------------
  // synchroniser lanes
  // ----------------------------------------------------------------
  localparam int SYN_W = 4;
  localparam int SYN_SCLK = 0;
  localparam int SYN_EN = 1;
  localparam int SYN_DIN = 2;
  localparam int SYN_APPLY = 3;
  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_BITCNT = 4'h8;
  localparam logic [ADDR_W-1:0] REG_BW = 4'hc;
  localparam int CTRL_RUN_BIT = 0;
  localparam logic CTRL_RUN_RESET = 1'b0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ARMED_BIT = 1;
  localparam int STAT_PEND_OFS = 8;
  localparam int BITCNT_W = 8;
  localparam logic [BITCNT_W-1:0] BITCNT_MAX = 8'hff;
  localparam int TICK_W = 8;
endpackage

// [common/divider_link_if.sv]
// setting hand-over between the chain and one divider channel
`timescale 1ns/1ns
`default_nettype none
interface divider_link_if;
  import pll_chain_pkg::*;
  div_setting_type setting;
  logic load_req;
  logic load_ack;
  modport ctrl (output setting, output load_req, input load_ack);
  modport chan (input setting, input load_req, output load_ack);
endinterface
`default_nettype wire

// [verilog/divider_channel.sv]
// one divider channel counting half vco phases
`timescale 1ns/1ns
`default_nettype none
module divider_channel
  import pll_chain_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic run_i,
  divider_link_if.chan link,
  output logic clk_o
);
  // ----------------------------------------------------------------
  // phase lengths in half vco cycles
  // ----------------------------------------------------------------
  function automatic logic [HALF_W-1:0] high_len(input div_setting_type s);
    logic [HALF_W-1:0] l;
    l = {s.hi, 1'b0} - {8'h00, s.odd};
    if (l == HALF_ZERO) l = HALF_ONE;
    return l;
  endfunction

  function automatic logic [HALF_W-1:0] low_len(input div_setting_type s);
    logic [HALF_W-1:0] l;
    l = {s.lo, 1'b0} + {8'h00, s.odd};
    if (l == HALF_ZERO) l = HALF_ONE;
    return l;
  endfunction

  div_setting_type cur_q;
  div_setting_type nxt_d;
  logic [HALF_W-1:0] cnt_q;
  logic ack_q;
  logic phase_end;
  logic boundary;
  logic take;

  assign phase_end = cur_q.bypass || (cnt_q <= HALF_ONE);
  assign boundary = tick_i && !clk_o && phase_end;
  assign take = link.load_req && !ack_q && (boundary || !run_i);
  assign nxt_d = take ? link.setting : cur_q;
  assign link.load_ack = ack_q;

  // ----------------------------------------------------------------
  // setting load at the period boundary, or at once while run_i is low
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_q <= '0;
      ack_q <= 1'b0;
    end else begin
      cur_q <= nxt_d;
      ack_q <= take;
    end
  end

  // ----------------------------------------------------------------
  // high and low phase counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_o <= 1'b0;
      cnt_q <= HALF_ONE;
    end else if (tick_i) begin
      if (!phase_end) begin
        cnt_q <= cnt_q - HALF_ONE;
      end else if (clk_o) begin
        clk_o <= 1'b0;
        cnt_q <= low_len(cur_q);
      end else begin
        clk_o <= 1'b1;
        cnt_q <= high_len(nxt_d);
      end
    end
  end

  chk_bypass_toggle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tick_i && cur_q.bypass |=> clk_o != $past(clk_o))
    else $error("bypassed divider did not follow the vco");
  chk_high_length: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(clk_o) && !cur_q.bypass |-> cnt_q == high_len(cur_q))
    else $error("high phase length wrong");
  chk_load_boundary: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(ack_q) |-> $rose(clk_o) || !$past(run_i))
    else $error("setting taken away from the period boundary");
endmodule // divider_channel
`default_nettype wire

// [verilog/pll_serial_reconfig_chain.sv]
// serial reconfiguration chain of the pll with divider channels
//
// Contract
// - serial bits enter on data, clocked by serial clock
// - shift per serial edge while enable high
// - first bit captured on second rising edge
// - one-cycle apply strobe loads dividers and bandwidth; the code takes apply only while it is high at a serial clock rising edge
// - complete high while busy, falls when loaded
// - whole sequence repeatable any number of times
// - each divider loads on its own clock; while run_i is low the code loads it at once, without waiting for a boundary
// - post-scale divider period is high plus low
// - bypass one divides by one, else sum
// - odd clear: plain high and low counts
// - odd set: high minus half, low plus half
// - 180 bits with pump, vco, filter, unused fields
// - nine divider blocks of eighteen bits each
// - first bit is low count lsb, first post-scale
// - last bit is loop filter msb
// - bypass ignores counts; vco divider bypass when clear
`timescale 1ns/1ns
`default_nettype none
module pll_serial_reconfig_chain
  import pll_chain_pkg::*;
#(
  parameter int VCO_HALF_DIV = 1,
  parameter int CHAIN_BITS = CHAIN_LEN
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic recfg_serial_clock_i,
  input wire logic recfg_shift_enable_i,
  input wire logic recfg_serial_in_i,
  input wire logic recfg_apply_strobe_i,
  output logic recfg_complete_o,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  output logic [DIV_COUNT-1:0] div_clk_o,
  output logic [CP_W-1:0] pump_current_o,
  output logic vco_post_div_o,
  output logic [LFC_W-1:0] loop_cap_o,
  output logic [LFR_W-1:0] loop_res_o
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (CHAIN_BITS != CHAIN_LEN) begin : g_bad_chain
    $error("chain length must match the field layout");
  end
  if (VCO_HALF_DIV < 1 || VCO_HALF_DIV > 256) begin : g_bad_div
    $error("vco half divider out of range");
  end

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(VCO_HALF_DIV - 1);

  function automatic div_setting_type block_of(input logic [CHAIN_LEN-1:0] c, input int b);
    return c[b*DIV_BITS +: DIV_BITS];
  endfunction

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [SYN_W-1:0] syn1_q;
  logic [SYN_W-1:0] syn2_q;
  logic sclk_prev_q;
  logic sclk_rise;
  logic en_s;
  logic din_s;
  logic apply_s;

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      syn1_q <= '0;
      syn2_q <= '0;
      sclk_prev_q <= 1'b0;
    end else begin
      syn1_q[SYN_SCLK] <= recfg_serial_clock_i;
      syn1_q[SYN_EN] <= recfg_shift_enable_i;
      syn1_q[SYN_DIN] <= recfg_serial_in_i;
      syn1_q[SYN_APPLY] <= recfg_apply_strobe_i;
      syn2_q <= syn1_q;
      sclk_prev_q <= syn2_q[SYN_SCLK];
    end
  end

  assign sclk_rise = syn2_q[SYN_SCLK] && !sclk_prev_q;
  assign en_s = syn2_q[SYN_EN];
  assign din_s = syn2_q[SYN_DIN];
  assign apply_s = syn2_q[SYN_APPLY];

  // ----------------------------------------------------------------
  // shift chain
  // ----------------------------------------------------------------
  logic [CHAIN_LEN-1:0] chain_q;
  logic armed_q;
  logic arm_go;
  logic shift_go;
  logic apply_go;
  logic [BITCNT_W-1:0] bitcnt_q;

  assign arm_go = sclk_rise && en_s && !armed_q;
  assign shift_go = sclk_rise && en_s && armed_q;
  assign apply_go = sclk_rise && apply_s;

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      armed_q <= 1'b0;
    end else if (!en_s) begin
      armed_q <= 1'b0;
    end else if (arm_go) begin
      armed_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      chain_q <= '0;
    end else if (shift_go) begin
      chain_q <= {din_s, chain_q[CHAIN_LEN-1:1]};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bitcnt_q <= '0;
    end else if (arm_go) begin
      bitcnt_q <= '0;
    end else if (shift_go && bitcnt_q != BITCNT_MAX) begin
      bitcnt_q <= bitcnt_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // active settings and completion
  // ----------------------------------------------------------------
  logic [CHAIN_LEN-1:0] active_q;
  logic [DIV_COUNT-1:0] pend_q;
  logic [DIV_COUNT-1:0] ack_w;
  logic busy_q;

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      active_q <= '0;
    end else if (apply_go) begin
      active_q <= chain_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pump_current_o <= '0;
      vco_post_div_o <= 1'b0;
      loop_cap_o <= '0;
      loop_res_o <= '0;
    end else if (apply_go) begin
      pump_current_o <= chain_q[CP_OFS +: CP_W];
      // a cleared bit selects the vco divider bypass
      vco_post_div_o <= chain_q[K_OFS];
      loop_cap_o <= chain_q[LFC_OFS +: LFC_W];
      loop_res_o <= chain_q[LFR_OFS +: LFR_W];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pend_q <= '0;
    end else if (apply_go) begin
      pend_q <= '1;
    end else begin
      pend_q <= pend_q & ~ack_w;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      busy_q <= 1'b0;
    end else if (apply_go) begin
      busy_q <= 1'b1;
    end else if (pend_q == '0) begin
      busy_q <= 1'b0;
    end
  end

  assign recfg_complete_o = busy_q;

  // ----------------------------------------------------------------
  // vco half phase tick
  // ----------------------------------------------------------------
  logic run_q;
  logic [TICK_W-1:0] tick_cnt_q;
  logic tick_q;

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (!run_q) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_LAST) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // divider channels
  // ----------------------------------------------------------------
  for (genvar g = 0; g < DIV_COUNT; g++) begin : g_div
    divider_link_if link ();
    assign link.setting = block_of(active_q, g);
    assign link.load_req = pend_q[g];
    assign ack_w[g] = link.load_ack;
    divider_channel u_chan (
      .clk_i(clk_i),
      .rst_n_i(rst_n_q),
      .tick_i(tick_q),
      .run_i(run_q),
      .link(link.chan),
      .clk_o(div_clk_o[g])
    );
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      run_q <= CTRL_RUN_RESET;
    end else if (reg_write_i && reg_addr_i == REG_CTRL) begin
      run_q <= reg_wdata_i[CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata_o <= '0;
    end else if (!reg_read_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= '0;
      unique case (reg_addr_i)
        REG_CTRL: begin
          reg_rdata_o[CTRL_RUN_BIT] <= run_q;
        end
        REG_STATUS: begin
          reg_rdata_o[STAT_BUSY_BIT] <= busy_q;
          reg_rdata_o[STAT_ARMED_BIT] <= armed_q;
          reg_rdata_o[STAT_PEND_OFS +: DIV_COUNT] <= pend_q;
        end
        REG_BITCNT: begin
          reg_rdata_o[BITCNT_W-1:0] <= bitcnt_q;
        end
        REG_BW: begin
          reg_rdata_o[CP_W-1:0] <= pump_current_o;
          reg_rdata_o[CP_W] <= vco_post_div_o;
          reg_rdata_o[CP_W+1 +: LFC_W] <= loop_cap_o;
          reg_rdata_o[CP_W+1+LFC_W +: LFR_W] <= loop_res_o;
        end
        default: begin
          reg_rdata_o <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_hold_contents: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    !shift_go |=> $stable(chain_q))
    else $error("chain moved without a shift edge");
  chk_arm_edge: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    arm_go |=> armed_q && $stable(chain_q))
    else $error("first enabled edge shifted data");
  chk_shift_order: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    shift_go |=> chain_q[CHAIN_LEN-1] == $past(din_s)
      && chain_q[CHAIN_LEN-2:0] == $past(chain_q[CHAIN_LEN-1:1]))
    else $error("shift direction wrong");
  chk_apply_copy: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    apply_go |=> active_q == $past(chain_q) && recfg_complete_o && pend_q == '1)
    else $error("apply did not copy the chain");
  chk_active_hold: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    !apply_go |=> $stable(active_q))
    else $error("active settings changed while shifting");
  chk_busy_end: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    busy_q && pend_q == '0 && !apply_go |=> !recfg_complete_o)
    else $error("complete stayed high after all loads");
  chk_bw_fields: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    apply_go |=> vco_post_div_o == $past(chain_q[K_OFS])
      && loop_res_o == $past(chain_q[LFR_OFS +: LFR_W]))
    else $error("bandwidth field taken from wrong bits");
  chk_status_read: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    reg_read_i && reg_addr_i == REG_STATUS |=> reg_rdata_o[STAT_BUSY_BIT] == $past(busy_q)
      ##1 reg_rdata_o == '0 || $past(reg_read_i))
    else $error("status read wrong");
endmodule // pll_serial_reconfig_chain
`default_nettype wire

// [tb/recfg_fabric_model.sv]
// fabric-side driver of the serial reconfiguration port
`timescale 1ns/1ns
`default_nettype none
module recfg_fabric_model
  import pll_chain_pkg::*;
#(
  parameter int HALF = 4
) (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [CHAIN_LEN-1:0] image_i,
  output logic sclk_o,
  output logic en_o,
  output logic din_o,
  output logic apply_o,
  output logic done_o
);
  task automatic wait_half();
    repeat (HALF) @(posedge clk_i);
  endtask
  // serial clock idles low between frames, 2.5 MHz inside them
  initial begin
    sclk_o = 1'b0;
    en_o = 1'b0;
    din_o = 1'b0;
    apply_o = 1'b0;
    done_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (start_i === 1'b1) begin
        done_o <= 1'b0;
        en_o <= 1'b1;
        wait_half();
        sclk_o <= 1'b1;
        wait_half();
        sclk_o <= 1'b0;
        for (int b = 0; b < CHAIN_LEN; b++) begin
          din_o <= image_i[b];
          wait_half();
          sclk_o <= 1'b1;
          wait_half();
          sclk_o <= 1'b0;
        end
        wait_half();
        en_o <= 1'b0;
        din_o <= ~din_o;
        wait_half();
        apply_o <= 1'b1;
        wait_half();
        sclk_o <= 1'b1;
        wait_half();
        sclk_o <= 1'b0;
        apply_o <= 1'b0;
        // the image carries no phase field, so no phase step follows here
        done_o <= 1'b1;
      end
    end
  end
endmodule // recfg_fabric_model
`default_nettype wire

// [tb/tb_pll_serial_reconfig_chain.sv]
// self-checking testbench of the pll serial reconfiguration chain
`timescale 1ns/1ns
`default_nettype none
module tb_pll_serial_reconfig_chain
  import pll_chain_pkg::*;
;
  logic clk_i = 1'b0;
  logic resetn_i, sclk, en, din, apply, start, done, complete, seen_busy;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [DATA_W-1:0] reg_wdata_i;
  logic [DATA_W-1:0] reg_rdata_o;
  logic reg_write_i, reg_read_i;
  logic [DIV_COUNT-1:0] div_clk_o;
  logic [CP_W-1:0] pump_current_o;
  logic vco_post_div_o;
  logic [LFC_W-1:0] loop_cap_o;
  logic [LFR_W-1:0] loop_res_o;
  logic [CHAIN_LEN-1:0] img;
  logic [10:0] cur_bw;
  int n_errors = 0;
  int n_compared = 0;
  int hi, per;
  always #25 clk_i = ~clk_i;
  pll_serial_reconfig_chain #(.VCO_HALF_DIV(1)) u_pll_serial_reconfig_chain (
    .clk_i(clk_i), .resetn_i(resetn_i), .recfg_serial_clock_i(sclk),
    .recfg_shift_enable_i(en), .recfg_serial_in_i(din), .recfg_apply_strobe_i(apply),
    .recfg_complete_o(complete), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
    .div_clk_o(div_clk_o), .pump_current_o(pump_current_o), .vco_post_div_o(vco_post_div_o),
    .loop_cap_o(loop_cap_o), .loop_res_o(loop_res_o));
  recfg_fabric_model u_recfg_fabric_model (
    .clk_i(clk_i), .start_i(start), .image_i(img), .sclk_o(sclk), .en_o(en),
    .din_o(din), .apply_o(apply), .done_o(done));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] bw_out();
    return {21'h0, loop_res_o, loop_cap_o, vco_post_div_o, pump_current_o};
  endfunction
  // bandwidth outputs hold while the chain shifts
  always @(posedge clk_i) begin
    if (complete === 1'b1) seen_busy <= 1'b1;
    if (en === 1'b1) check(bw_out(), {21'h0, cur_bw});
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clk_i);
    reg_write_i <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clk_i);
    reg_read_i <= 1'b0;
    #1;
    check(reg_rdata_o, exp);
  endtask
  task automatic step(inout int n);
    @(posedge clk_i);
    #1;
    n++;
  endtask
  task automatic measure(input int i, output int hi_n, output int per_n);
    int n;
    n = 0;
    hi_n = 0;
    while (div_clk_o[i] !== 1'b0 && n < 40) step(n);
    while (div_clk_o[i] !== 1'b1 && n < 80) step(n);
    while (div_clk_o[i] === 1'b1 && n < 120) begin
      step(n);
      hi_n++;
    end
    per_n = hi_n;
    while (div_clk_o[i] === 1'b0 && n < 160) begin
      step(n);
      per_n++;
    end
    // a clean period ends well before the first bound
    if (n >= 40) n_errors++;
  endtask
  task automatic reconfig(input div_setting_type d0, input div_setting_type d1,
                          input logic [10:0] bw);
    int n;
    img = '0;
    img[DIV_BITS-1:0] = d0;
    img[DIV_BITS +: DIV_BITS] = d1;
    img[CP_OFS +: CP_W] = bw[2:0];
    img[K_OFS] = bw[3];
    img[LFC_OFS +: LFC_W] = bw[5:4];
    img[LFR_OFS +: LFR_W] = bw[10:6];
    seen_busy <= 1'b0;
    @(posedge clk_i);
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    for (n = 0; n < 3000 && done !== 1'b1; n++) @(posedge clk_i);
    while (n < 3300 && !(seen_busy === 1'b1 && complete === 1'b0)) step(n);
    if (n >= 3300) begin
      n_errors++;
      stop_test();
    end
    check({31'h0, seen_busy}, 32'h1);
    cur_bw = bw;
    check(bw_out(), {21'h0, bw});
    rd(REG_BW, {21'h0, bw});
    rd(REG_STATUS, 32'h0);
    rd(REG_BITCNT, 32'(CHAIN_LEN));
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn_i = 1'b0;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    reg_write_i = 1'b0;
    reg_read_i = 1'b0;
    start = 1'b0;
    seen_busy = 1'b0;
    cur_bw = '0;
    img = '0;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    check(bw_out(), 32'h0);
    rd(REG_CTRL, 32'h0);
    rd(REG_STATUS, 32'h0);
    rd(REG_BITCNT, 32'h0);
    wr(REG_BW, 32'hffffffff);
    wr(4'h2, 32'hffffffff);
    rd(REG_BW, 32'h0);
    rd(4'h2, 32'h0);
    reconfig(div_setting_type'{1'b0, 1'b0, 8'h02, 8'h01},
             div_setting_type'{1'b0, 1'b1, 8'h05, 8'h05}, {5'h13, 2'h2, 1'b1, 3'h5});
    wr(REG_CTRL, 32'h1);
    rd(REG_CTRL, 32'h1);
    measure(0, hi, per);
    check(32'(hi), 32'h4);
    check(32'(per), 32'h6);
    measure(1, hi, per);
    check(32'(per), 32'h2);
    reconfig(div_setting_type'{1'b1, 1'b0, 8'h02, 8'h01},
             div_setting_type'{1'b0, 1'b0, 8'h01, 8'h02}, {5'h0c, 2'h1, 1'b0, 3'h2});
    measure(0, hi, per);
    check(32'(hi), 32'h3);
    check(32'(per), 32'h6);
    measure(1, hi, per);
    check(32'(hi), 32'h2);
    check(32'(per), 32'h6);
    // controller resets the pll after the divider change
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    check({23'h0, div_clk_o}, 32'h0);
    check(bw_out(), 32'h0);
    @(posedge clk_i);
    resetn_i <= 1'b1;
    cur_bw = '0;
    repeat (5) @(posedge clk_i);
    #1;
    check({23'h0, div_clk_o}, 32'h0);
    rd(REG_CTRL, 32'h0);
    rd(REG_BW, 32'h0);
    rd(REG_STATUS, 32'h0);
    stop_test();
  end
endmodule // tb_pll_serial_reconfig_chain
`default_nettype wire
